// *** core/enc_out_pkg.sv ***
// Constants shared by the encoder pulse output logic.
// Assumes a single 100 MHz system clock domain.
package enc_out_pkg;

  // ==========================================================================
  // Setting range and defaults
  localparam logic [15:0] SET_DEFAULT   = 16'h0fa0;   // 4000 edges per rev
  localparam logic [17:0] EDGES_MAX     = 18'h10000;  // 65535 rounded up to 4 edges
  localparam int          RES_DEFAULT   = 10000;      // Encoder counts per rev
  localparam int          DIV_WIDTH     = 24;

  // ==========================================================================
  // Quadrature grouping and rounding
  localparam int          EDGE_SHIFT    = 2;          // Four edges per phase pulse
  localparam logic [17:0] EDGE_MASK     = 18'h00003;
  localparam logic [17:0] ROUND_HALF    = 18'h00002;  // Half of four edges

  // ==========================================================================
  // Interpretation of the setting
  localparam logic        MODE_DESIGNATE = 1'b0;
  localparam logic        MODE_DIVIDE    = 1'b1;

endpackage

// *** core/edge_ratio_divider.sv ***
// Serial restoring divider for the division-ratio interpretation.
// Assumes start is only raised while busy is low.
`timescale 1ns/100ps
module edge_ratio_divider #(
  parameter int W = 24
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         start,
  input  wire logic [W-1:0] dividend,
  input  wire logic [W-1:0] divisor,
  output logic              busy,
  output logic              done,
  output logic [W-1:0]      quotient
);
  import enc_out_pkg::*;

  localparam int CW = $clog2(W + 1);

  typedef enum logic [1:0] {
    IDLE = 2'b00,
    RUN  = 2'b01,
    DONE = 2'b11
  } div_state_e;

  div_state_e     state;
  div_state_e     next_state;
  logic [W-1:0]   num;
  logic [W-1:0]   num_orig;
  logic [W-1:0]   den;
  logic [W-1:0]   rem;
  logic [CW-1:0]  cnt;

  // ==========================================================================
  // One quotient bit per cycle
  wire  [W:0]     shifted = {rem, num[W-1]};
  wire  [W:0]     trial   = shifted - {1'b0, den};
  wire            fits    = ~trial[W];
  wire  [W-1:0]   next_rem = fits ? trial[W-1:0] : shifted[W-1:0];

  always_comb begin
    next_state = state;
    unique case (state)
      IDLE: if (start) next_state = RUN;
      RUN:  if (cnt == CW'(1)) next_state = DONE;
      DONE: next_state = IDLE;
      default: next_state = IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state    <= IDLE;
      num      <= '0;
      num_orig <= '0;
      den      <= '0;
      rem      <= '0;
      quotient <= '0;
      cnt      <= '0;
    end else begin
      state <= next_state;
      if (state == IDLE && start) begin
        num      <= dividend;
        num_orig <= dividend;
        den      <= divisor;
        rem      <= '0;
        cnt      <= CW'(W);
      end else if (state == RUN) begin
        num      <= {num[W-2:0], 1'b0};
        rem      <= next_rem;
        quotient <= {quotient[W-2:0], fits};
        cnt      <= cnt - CW'(1);
      end
    end
  end

  assign busy = (state != IDLE);
  assign done = (state == DONE);

  // ==========================================================================
  // Checks
  chk_quotient_round: assert property (@(posedge clk) disable iff (!reset_n)
    done |-> ({{W{1'b0}}, quotient} * {{W{1'b0}}, den} <= {{W{1'b0}}, num_orig})
          && ({{W{1'b0}}, num_orig} < ({{W{1'b0}}, quotient} + 1) * {{W{1'b0}}, den}))
    else $error("divider quotient out of range");

  chk_divide_time: assert property (@(posedge clk) disable iff (!reset_n)
    (state == IDLE && start) |-> ##(W + 1) done)
    else $error("divider did not finish in time");

endmodule

// *** core/encoder_pulse_output_divider.sv ***
// Encoder emulation output: motor encoder steps in, A/B quadrature out.
// Assumes encoder steps and setting inputs are synchronous to SYS_CLK.
`timescale 1ns/100ps
module encoder_pulse_output_divider #(
  parameter int RES = enc_out_pkg::RES_DEFAULT,
  parameter int AW  = enc_out_pkg::DIV_WIDTH
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  input  wire logic [15:0] QUAD_PULSE_SETTING,
  input  wire logic        PULSE_MODE,
  input  wire logic        ENC_STEP,
  input  wire logic        ENC_DIR,
  output logic             OUT_A,
  output logic             OUT_B
);
  import enc_out_pkg::*;

  localparam int W = enc_out_pkg::DIV_WIDTH;

  function automatic logic [17:0] designate_edges(input logic [15:0] s);
    designate_edges = ({2'b00, s} + ROUND_HALF) & ~EDGE_MASK;
  endfunction

  logic [15:0]        setting_seen;
  logic               mode_seen;
  logic [17:0]        edges_per_rev;
  logic signed [AW-1:0] acc;
  logic [1:0]         quad;
  logic               div_busy;
  logic               div_done;
  logic [W-1:0]       div_quot;

  // ==========================================================================
  // Setting interpretation
  wire        changed    = (QUAD_PULSE_SETTING != setting_seen) || (PULSE_MODE != mode_seen);
  wire        update_req = changed && !div_busy;
  wire        div_start  = update_req && (PULSE_MODE == MODE_DIVIDE);
  wire [15:0] safe_set   = (QUAD_PULSE_SETTING == 16'h0000) ? 16'h0001 : QUAD_PULSE_SETTING;
  wire [W-1:0] div_num   = W'(RES) + W'({safe_set, 1'b0});
  wire [W-1:0] div_den   = W'({safe_set, 2'b00});
  wire [17:0] div_edges  = {div_quot[15:0], 2'b00};

  edge_ratio_divider #(.W(W)) ratio_div (
    .clk      (SYS_CLK),
    .reset_n  (RESET_N),
    .start    (div_start),
    .dividend (div_num),
    .divisor  (div_den),
    .busy     (div_busy),
    .done     (div_done),
    .quotient (div_quot)
  );

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      setting_seen  <= SET_DEFAULT;
      mode_seen     <= MODE_DESIGNATE;
      edges_per_rev <= {2'b00, SET_DEFAULT};
    end else if (update_req) begin
      setting_seen <= QUAD_PULSE_SETTING;
      mode_seen    <= PULSE_MODE;
      if (PULSE_MODE == MODE_DESIGNATE) begin
        edges_per_rev <= designate_edges(QUAD_PULSE_SETTING);
      end
    end else if (div_done && mode_seen == MODE_DIVIDE) begin
      edges_per_rev <= div_edges;
    end
  end

  // ==========================================================================
  // Rate scaling: edges_per_rev output edges for every RES encoder steps
  wire signed [AW-1:0] res_s   = AW'(RES);
  wire signed [AW-1:0] step_s  = AW'(edges_per_rev);
  wire signed [AW-1:0] add     = !ENC_STEP ? '0 : (ENC_DIR ? -step_s : step_s);
  wire signed [AW-1:0] sum     = acc + add;
  wire                 fwd     = (sum >= res_s);
  wire                 bwd     = (sum <= -res_s);
  wire signed [AW-1:0] next_acc = fwd ? sum - res_s : (bwd ? sum + res_s : sum);
  wire [1:0]           next_quad = fwd ? quad + 2'd1 : (bwd ? quad - 2'd1 : quad);

  // Gray order of the phase pair: forward 00, 01, 11, 10
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      acc   <= '0;
      quad  <= 2'b00;
      OUT_A <= 1'b0;
      OUT_B <= 1'b0;
    end else begin
      acc   <= next_acc;
      quad  <= next_quad;
      OUT_A <= next_quad[1];
      OUT_B <= next_quad[1] ^ next_quad[0];
    end
  end

  // ==========================================================================
  // Checks
  chk_reset_default: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    $rose(RESET_N) |-> edges_per_rev == {2'b00, SET_DEFAULT})
    else $error("edge count not at default after reset");

  chk_edges_bound: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    edges_per_rev <= EDGES_MAX)
    else $error("edge count above range");

  chk_edge_groups: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (edges_per_rev & EDGE_MASK) == 18'h00000)
    else $error("edge count not whole phase pulses");

  chk_mode_follow: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (PULSE_MODE != mode_seen) && $stable(PULSE_MODE) |-> ##[1:30] (mode_seen == PULSE_MODE))
    else $error("mode change not taken");

  chk_designate_edges: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    update_req && PULSE_MODE == MODE_DESIGNATE
      |=> edges_per_rev == designate_edges($past(QUAD_PULSE_SETTING)))
    else $error("designation edge count wrong");

  chk_divide_edges: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    div_done && mode_seen == MODE_DIVIDE && !update_req |=> edges_per_rev == $past(div_edges))
    else $error("division edge count not loaded");

  chk_single_phase: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    !($changed(OUT_A) && $changed(OUT_B)))
    else $error("both phases moved together");

  chk_forward_order: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fwd && !OUT_A && !OUT_B |=> !OUT_A && OUT_B)
    else $error("forward step in wrong phase order");

  // ==========================================================================
  // Checks: phase order, phase hold without an edge, and phase level after reset
  chk_reverse_order: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    bwd && !OUT_A && !OUT_B
      |=> OUT_A && !OUT_B)
    else $error("reverse step in wrong phase order");

  chk_forward_a_rise: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fwd && !OUT_A && OUT_B
      |=> OUT_A && OUT_B)
    else $error("forward step did not raise phase A");

  chk_forward_b_fall: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fwd && OUT_A && OUT_B
      |=> OUT_A && !OUT_B)
    else $error("forward step did not drop phase B");

  chk_forward_wrap: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fwd && OUT_A && !OUT_B
      |=> !OUT_A && !OUT_B)
    else $error("forward step did not close the cycle");

  chk_reverse_b_rise: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    bwd && OUT_A && !OUT_B
      |=> OUT_A && OUT_B)
    else $error("reverse step did not raise phase B");

  chk_reverse_a_fall: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    bwd && OUT_A && OUT_B
      |=> !OUT_A && OUT_B)
    else $error("reverse step did not drop phase A");

  chk_reverse_wrap: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    bwd && !OUT_A && OUT_B
      |=> !OUT_A && !OUT_B)
    else $error("reverse step did not close the cycle");

  chk_outputs_stand: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    !fwd && !bwd
      |=> $stable(OUT_A) && $stable(OUT_B))
    else $error("phase moved without an edge");

  chk_one_step: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fwd || bwd
      |=> $changed(OUT_A) || $changed(OUT_B))
    else $error("edge produced no phase change");

  chk_reset_outputs: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    $rose(RESET_N)
      |-> !OUT_A && !OUT_B)
    else $error("phases not low after reset");

  // ==========================================================================
  // Checks: setting path
  chk_setting_taken: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    update_req
      |=> setting_seen == $past(QUAD_PULSE_SETTING) && mode_seen == $past(PULSE_MODE))
    else $error("setting change not taken");

  chk_change_held: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    changed && div_busy
      |=> $stable(setting_seen) && $stable(mode_seen))
    else $error("setting taken while dividing");

  chk_edges_stand: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    !update_req && !div_done
      |=> $stable(edges_per_rev))
    else $error("edge count moved without a change");

  chk_reset_mode: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    $rose(RESET_N)
      |-> mode_seen == MODE_DESIGNATE)
    else $error("mode not designation after reset");

  chk_divisor_nonzero: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    div_start
      |-> div_den != '0)
    else $error("division started with zero divisor");

  chk_quotient_fits: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    div_done
      |-> div_quot[W-1:16] == '0)
    else $error("division result wider than edge count");

endmodule

// *** testbench/quad_counter_model.sv ***
// Positioning controller model: counts A/B quadrature edges four times.
// Assumes A and B are settled at each rising edge of the system clock.
`timescale 1ns/100ps
module quad_counter_model (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic phase_a,
  input  wire logic phase_b,
  output int        position,
  output int        bad_steps
);
  logic [1:0] last;
  logic [1:0] delta;

  function automatic logic [1:0] phase_index(input logic [1:0] ab);
    return {ab[1], ab[1] ^ ab[0]};
  endfunction

  assign delta = phase_index({phase_a, phase_b}) - phase_index(last);

  // ==========================================================================
  // Four-times edge counting
  // A step of one in the cycle 00,01,11,10 counts forward, three back.
  // A step of two means both phases moved at once and is counted as bad.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last      <= 2'h0;
      position  <= 0;
      bad_steps <= 0;
    end else begin
      last <= {phase_a, phase_b};
      case (delta)
        2'h1: position <= position + 1;
        2'h3: position <= position - 1;
        2'h2: bad_steps <= bad_steps + 1;
        default: ;
      endcase
    end
  end
endmodule

// *** testbench/tb.sv ***
// Testbench for the encoder pulse output block with a quadrature counter.
// Assumes a 100 MHz clock and a reduced encoder resolution of 1000.
`timescale 1ns/100ps
module tb;
  import enc_out_pkg::*;
  localparam int RES_T = 1000;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [15:0] setting = SET_DEFAULT;
  logic        mode    = MODE_DESIGNATE;
  logic        step    = 1'b0;
  logic        dir     = 1'b0;
  logic        out_a;
  logic        out_b;
  int          pos;
  int          bad;
  int          expect_pos = 0;
  int          err_count = 0;
  int          comparisons = 0;

  always #5 sys_clk = ~sys_clk;

  encoder_pulse_output_divider #(.RES(RES_T)) DUT (
    .SYS_CLK(sys_clk), .RESET_N(reset_n), .QUAD_PULSE_SETTING(setting),
    .PULSE_MODE(mode), .ENC_STEP(step), .ENC_DIR(dir), .OUT_A(out_a), .OUT_B(out_b));

  quad_counter_model far_end (
    .clk(sys_clk), .reset_n(reset_n), .phase_a(out_a), .phase_b(out_b),
    .position(pos), .bad_steps(bad));

  // ==========================================================================
  // Shared helpers
  function automatic int edges_per_rev(input int s, input logic m);
    // Nearest whole phase pulse, halves away from zero
    if (m == MODE_DESIGNATE) return 4 * int'(s / 4.0);
    return 4 * int'(RES_T / (4.0 * s));
  endfunction

  task automatic configure(input logic [15:0] s, input logic m);
    @(posedge sys_clk);
    setting <= s;
    mode    <= m;
    repeat (40) @(posedge sys_clk);
  endtask

  // Step spacing keeps the edge rate at or below 1.3 million per second.
  task automatic move(input int n, input logic back, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      step <= 1'b1;
      dir  <= back;
      @(posedge sys_clk);
      step <= 1'b0;
      repeat (gap - 2) @(posedge sys_clk);
    end
    repeat (300) @(posedge sys_clk);
  endtask

  task automatic check(input string what);
    comparisons++;
    if (pos !== expect_pos || bad !== 0) begin
      err_count++;
      $display("[ERR] %0t %s: position %0d expected %0d, bad %0d",
               $time, what, pos, expect_pos, bad);
    end
  endtask

  task automatic results;
    $display("Comparisons %0d, errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic default_count;
    check("idle after reset");
    move(50, 1'b0, 320);
    expect_pos += edges_per_rev(int'(SET_DEFAULT), MODE_DESIGNATE) * 50 / RES_T;
    check("default setting");
  endtask

  task automatic rounding;
    configure(16'h0191, MODE_DESIGNATE);
    move(500, 1'b0, 32);
    expect_pos += edges_per_rev(401, MODE_DESIGNATE) * 500 / RES_T;
    check("setting 401 rounds down");
    configure(16'h0192, MODE_DESIGNATE);
    move(500, 1'b0, 32);
    expect_pos += edges_per_rev(402, MODE_DESIGNATE) * 500 / RES_T;
    check("setting 402 rounds up");
  endtask

  task automatic division;
    configure(16'h0008, MODE_DIVIDE);
    move(1000, 1'b0, 10);
    expect_pos += edges_per_rev(8, MODE_DIVIDE);
    check("division ratio 8");
  endtask

  task automatic reverse;
    move(1000, 1'b1, 10);
    expect_pos -= edges_per_rev(8, MODE_DIVIDE);
    check("reverse revolution");
  endtask

  task automatic busy_hold;
    @(posedge sys_clk);
    setting <= 16'h0004;
    repeat (3) @(posedge sys_clk);
    setting <= 16'h0190;
    mode    <= MODE_DESIGNATE;
    repeat (40) @(posedge sys_clk);
    move(250, 1'b0, 32);
    expect_pos += edges_per_rev(400, MODE_DESIGNATE) * 250 / RES_T;
    check("change held during division");
  endtask

  task automatic reset_again;
    @(posedge sys_clk);
    reset_n <= 1'b0;
    setting <= SET_DEFAULT;
    mode    <= MODE_DESIGNATE;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    expect_pos = 0;
    repeat (4) @(posedge sys_clk);
    check("idle after second reset");
    move(10, 1'b0, 320);
    expect_pos += edges_per_rev(int'(SET_DEFAULT), MODE_DESIGNATE) * 10 / RES_T;
    check("default after second reset");
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    err_count++;
    $display("[ERR] %0t run limit reached", $time);
    results();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    default_count();
    rounding();
    division();
    reverse();
    busy_hold();
    reset_again();
    results();
  end
endmodule
